/* scd_pkg.sv */
package scd_pkg;

  // ==========================================================================
  // Widths and instruction field low bits
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned FIELD_W   = 4;
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned OPC_LSB   = 0;
  localparam int unsigned FUNC_LSB  = 4;
  localparam int unsigned REGA_LSB  = 8;
  localparam int unsigned REGB_LSB  = 12;

  // ==========================================================================
  // Register index encoding
  localparam logic [3:0] GEN_LAST_IDX = 4'hC;
  localparam logic [3:0] TEMP_IDX     = 4'hD;
  localparam logic [3:0] ZERO_IDX     = 4'hE;
  localparam logic [3:0] ONES_IDX     = 4'hF;

  // ==========================================================================
  // Constants, reset values and default sizes
  localparam logic [15:0] ZERO_VAL   = 16'h0000;
  localparam logic [15:0] ONES_VAL   = 16'hFFFF;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [15:0] PC_STEP    = 16'h0001;
  localparam logic [15:0] REG_RST    = 16'h0000;
  localparam int unsigned RET_DEPTH_DEF = 8;
  localparam int unsigned IO_ADDR_W_DEF = 8;
  localparam int unsigned IO_DATA_W_DEF = 8;

  // ==========================================================================
  // Operation selectors from control
  typedef enum logic [3:0] {
    SCD_ALU_ADD, SCD_ALU_SUB, SCD_ALU_MUL, SCD_ALU_DIV,
    SCD_ALU_AND, SCD_ALU_OR,  SCD_ALU_XOR, SCD_ALU_NOT,
    SCD_ALU_NEG
  } scd_alu_op_e;

  typedef enum logic [2:0] {
    SCD_SHF_ROL, SCD_SHF_ROR, SCD_SHF_LSL,
    SCD_SHF_LSR, SCD_SHF_ASL, SCD_SHF_ASR
  } scd_shf_op_e;

  typedef enum logic [2:0] {
    SCD_CND_ALWAYS, SCD_CND_EQ, SCD_CND_NE, SCD_CND_GT,
    SCD_CND_GE,     SCD_CND_LT, SCD_CND_LE, SCD_CND_NEVER
  } scd_cond_e;

  typedef enum logic [2:0] {
    SCD_WB_ALU, SCD_WB_SHIFT, SCD_WB_DMEM, SCD_WB_IO, SCD_WB_OPER
  } scd_wb_sel_e;

endpackage

/* scd_rf_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Register file access bundle
interface scd_rf_if;
  logic [3:0]  rd_a_idx;
  logic [3:0]  rd_b_idx;
  logic [15:0] rd_a;
  logic [15:0] rd_b;
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [15:0] wr_data;
  logic        tmp_wr_en;
  logic [15:0] tmp_data;

  modport dp (
    output rd_a_idx, rd_b_idx, wr_en, wr_idx, wr_data, tmp_wr_en, tmp_data,
    input  rd_a, rd_b
  );

  modport rf (
    input  rd_a_idx, rd_b_idx, wr_en, wr_idx, wr_data, tmp_wr_en, tmp_data,
    output rd_a, rd_b
  );
endinterface

`default_nettype wire

/* scd_regfile.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Register file: thirteen general registers, temp, two constants
module scd_regfile (
  input wire logic clk,
  input wire logic rst,
  scd_rf_if.rf     bus
);

  logic [15:0] regs [0:12];
  logic [15:0] temp_reg;

  // Constant indices are decoded here, never stored
  function automatic logic [15:0] scd_rd(input logic [3:0] idx, input logic [15:0] val,
                                         input logic [15:0] tmp);
    if (idx == scd_pkg::ZERO_IDX) begin
      return scd_pkg::ZERO_VAL;
    end else if (idx == scd_pkg::ONES_IDX) begin
      return scd_pkg::ONES_VAL;
    end else if (idx == scd_pkg::TEMP_IDX) begin
      return tmp;
    end
    return val;
  endfunction

  // Reads are combinational so operands latch in the same cycle
  assign bus.rd_a = scd_rd(bus.rd_a_idx,
                           regs[bus.rd_a_idx > 4'hC ? 4'hC : bus.rd_a_idx], temp_reg);
  assign bus.rd_b = scd_rd(bus.rd_b_idx,
                           regs[bus.rd_b_idx > 4'hC ? 4'hC : bus.rd_b_idx], temp_reg);

  // General write port; temp and constants unreachable
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 13; i++) begin
        regs[i] <= scd_pkg::REG_RST;
      end
    end else if (bus.wr_en && bus.wr_idx <= scd_pkg::GEN_LAST_IDX) begin
      regs[bus.wr_idx] <= bus.wr_data;
    end
  end

  // Own temp port: second result lands in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_reg <= scd_pkg::REG_RST;
    end else if (bus.tmp_wr_en) begin
      temp_reg <= bus.tmp_data;
    end
  end

endmodule

`default_nettype wire

/* scd_shifter.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Barrel shifter built on a single left rotator
module scd_shifter (
  input  wire logic [15:0]       din,
  input  wire logic [3:0]        amount,
  input  wire scd_pkg::scd_shf_op_e op,
  output logic      [15:0]       dout
);

  logic [3:0]  rot;
  logic        right;
  logic        fill;
  logic [15:0] rotated;
  logic [15:0] keep;

  // right moves by width minus count
  always_comb begin
    right = (op == scd_pkg::SCD_SHF_ROR) || (op == scd_pkg::SCD_SHF_LSR) ||
            (op == scd_pkg::SCD_SHF_ASR);
    rot   = right ? 4'(4'h0 - amount) : amount;
    fill  = (op == scd_pkg::SCD_SHF_ASR) ? din[15] : 1'b0;
  end

  assign rotated = 16'((din << rot) | (din >> (5'h10 - {1'b0, rot})));

  // Wrapped bits become zeros or sign copies
  // rotate, left shifts, right shifts
  always_comb begin
    case (op)
      scd_pkg::SCD_SHF_ROL,
      scd_pkg::SCD_SHF_ROR: keep = 16'hFFFF;
      scd_pkg::SCD_SHF_LSL,
      scd_pkg::SCD_SHF_ASL: keep = 16'(16'hFFFF << amount);
      scd_pkg::SCD_SHF_LSR,
      scd_pkg::SCD_SHF_ASR: keep = 16'(16'hFFFF >> amount);
      default:              keep = 16'hFFFF;
    endcase
    dout = (rotated & keep) | ({16{fill}} & ~keep);
  end

endmodule

`default_nettype wire

/* scd_datapath.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Index 14 reads zero, index 15 reads all ones.
// - Fetch and branch hit code memory; loads and stores hit data memory.
// - Each memory holds 65536 sixteen-bit words, word access only.
// - Instruction word splits into four nibble fields.
// - Indices 0-12 general, 13 temp, 14 zero, 15 ones.
// - Immediate or absolute operands only for loads and stores.
// - PC plus one formed every cycle, muxed with branch target.
// - Return addresses live in a 16-bit bidirectional shift register.
// - Operand registers load from next instruction word or register file.
// - One writeback multiplexer picks the unit result.
// - ALU and multiplier are purely combinational.
// - Multiply high half or divide remainder goes to temp in same cycle.
// - Operands drive data memory buses; control adds a read stall.
// - I/O and video buses carry operands; control gives enables.
// - I/O unit both reads and writes peripheral words.
// - Shifter offers rotates, arithmetic shifts and logical shifts.
// - Right moves use left rotation by width minus count plus fill.
// - Branch uses equal and greater-than comparators; others derived.
// - True condition reloads PC from target, else PC keeps next address.
module scd_datapath #(
  parameter int unsigned RET_DEPTH = scd_pkg::RET_DEPTH_DEF,
  parameter int unsigned IO_ADDR_W = scd_pkg::IO_ADDR_W_DEF,
  parameter int unsigned IO_DATA_W = scd_pkg::IO_DATA_W_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Control: fetch
  input  wire logic                 pc_load_en,
  input  wire logic                 ir_load_en,
  input  wire logic                 bt_load_en,
  input  wire logic                 branch_en,
  input  wire logic                 call_en,
  input  wire logic                 return_en,
  input  wire scd_pkg::scd_cond_e   branch_cond,
  // Control: decode
  input  wire logic                 op1_load_en,
  input  wire logic                 op2_load_en,
  input  wire logic                 op1_imm_sel,
  input  wire logic                 op2_imm_sel,
  input  wire logic                 ldst_instr,
  // Control: execute
  input  wire scd_pkg::scd_alu_op_e alu_op,
  input  wire scd_pkg::scd_shf_op_e shift_op,
  input  wire scd_pkg::scd_wb_sel_e wb_sel,
  input  wire logic                 rf_write_en,
  input  wire logic                 dmem_write_en,
  input  wire logic                 io_read_en,
  input  wire logic                 io_write_en,
  input  wire logic                 video_write_en,
  // Decode results for control
  output logic [3:0]                opcode,
  output logic [3:0]                func_field,
  output logic                      branch_taken,
  output logic                      stack_empty,
  output logic                      stack_full,
  // Instruction memory
  output logic [15:0]               imem_addr,
  input  wire logic [15:0]          imem_rdata,
  // Data memory
  output logic [15:0]               dmem_addr,
  output logic [15:0]               dmem_wdata,
  output logic                      dmem_we,
  input  wire logic [15:0]          dmem_rdata,
  // Peripheral I/O bus
  output logic [IO_ADDR_W-1:0]      io_addr,
  output logic [IO_DATA_W-1:0]      io_wdata,
  output logic                      io_rd,
  output logic                      io_wr,
  input  wire logic [IO_DATA_W-1:0] io_rdata,
  // Video bus
  output logic [15:0]               vid_addr,
  output logic [15:0]               vid_data,
  output logic                      vid_we
);

  // ==========================================================================
  // Declarations
  scd_rf_if rf ();

  logic [15:0] pc;
  logic [15:0] pc_inc;
  logic [15:0] next_pc;
  logic [15:0] ir;
  logic [15:0] branch_target;
  logic [15:0] op1;
  logic [15:0] op2;
  logic [15:0] ret_stack [0:RET_DEPTH-1];
  logic [$clog2(RET_DEPTH+1)-1:0] ret_count;
  logic        push;
  logic        pop;
  logic        cmp_eq;
  logic        cmp_gt;
  logic [15:0] alu_result;
  logic [15:0] alu_extra;
  logic        alu_has_extra;
  logic [15:0] shift_result;
  logic [15:0] wb_data;

  // ==========================================================================
  // Instruction fields
  // four nibble fields
  always_comb begin
    opcode     = ir[scd_pkg::OPC_LSB  +: scd_pkg::FIELD_W];
    func_field = ir[scd_pkg::FUNC_LSB +: scd_pkg::FIELD_W];
  end

  assign rf.rd_a_idx = ir[scd_pkg::REGA_LSB +: scd_pkg::FIELD_W];
  assign rf.rd_b_idx = ir[scd_pkg::REGB_LSB +: scd_pkg::FIELD_W];

  // ==========================================================================
  // Fetch
  // increment every cycle
  assign pc_inc = pc + scd_pkg::PC_STEP;

  assign imem_addr = pc;

  always_comb begin
    if (return_en) begin
      next_pc = ret_stack[0];
    end else if (branch_en && branch_taken) begin
      next_pc = branch_target;
    end else begin
      next_pc = pc_inc;
    end
  end

  // PC always points at the next word
  always_ff @(posedge clk) begin
    if (rst) begin
      pc <= scd_pkg::PC_RST;
    end else if (pc_load_en) begin
      pc <= next_pc;
    end
  end

  // Instruction register
  always_ff @(posedge clk) begin
    if (rst) begin
      ir <= scd_pkg::REG_RST;
    end else if (ir_load_en) begin
      ir <= imem_rdata;
    end
  end

  // Target is the word after the instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      branch_target <= scd_pkg::REG_RST;
    end else if (bt_load_en) begin
      branch_target <= imem_rdata;
    end
  end

  // ==========================================================================
  // Return address stack
  // Only a taken call pushes
  assign push = pc_load_en && call_en && branch_en && branch_taken && !return_en;
  assign pop  = pc_load_en && return_en;

  assign stack_empty = (ret_count == '0);
  assign stack_full  = (ret_count == ($clog2(RET_DEPTH+1))'(RET_DEPTH));

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < RET_DEPTH; i++) begin
        ret_stack[i] <= scd_pkg::REG_RST;
      end
    end else if (push) begin
      ret_stack[0] <= pc;
      for (int i = 1; i < RET_DEPTH; i++) begin
        ret_stack[i] <= ret_stack[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < RET_DEPTH - 1; i++) begin
        ret_stack[i] <= ret_stack[i+1];
      end
      ret_stack[RET_DEPTH-1] <= scd_pkg::REG_RST;
    end
  end

  // Count saturates; overflow drops the oldest entry
  always_ff @(posedge clk) begin
    if (rst) begin
      ret_count <= '0;
    end else if (push && !stack_full) begin
      ret_count <= ret_count + 1'b1;
    end else if (pop && !stack_empty) begin
      ret_count <= ret_count - 1'b1;
    end
  end

  // ==========================================================================
  // Operand registers
  // immediate only for load/store
  always_ff @(posedge clk) begin
    if (rst) begin
      op1 <= scd_pkg::REG_RST;
    end else if (op1_load_en) begin
      op1 <= (op1_imm_sel && ldst_instr) ? imem_rdata : rf.rd_a;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op2 <= scd_pkg::REG_RST;
    end else if (op2_load_en) begin
      op2 <= (op2_imm_sel && ldst_instr) ? imem_rdata : rf.rd_b;
    end
  end

  // ==========================================================================
  // Arithmetic and logic unit
  // Signed; divide by zero gives all ones, remainder = dividend
  // purely combinational ALU
  always_comb begin
    logic signed [31:0] prod;
    prod          = 32'($signed(op1)) * 32'($signed(op2));
    alu_result    = scd_pkg::ZERO_VAL;
    alu_extra     = scd_pkg::ZERO_VAL;
    alu_has_extra = 1'b0;
    case (alu_op)
      scd_pkg::SCD_ALU_ADD: alu_result = op1 + op2;
      scd_pkg::SCD_ALU_SUB: alu_result = op1 - op2;
      scd_pkg::SCD_ALU_MUL: begin
        alu_result    = prod[15:0];
        alu_extra     = prod[31:16];
        alu_has_extra = 1'b1;
      end
      scd_pkg::SCD_ALU_DIV: begin
        alu_has_extra = 1'b1;
        if (op2 == scd_pkg::ZERO_VAL) begin
          alu_result = scd_pkg::ONES_VAL;
          alu_extra  = op1;
        end else begin
          alu_result = 16'($signed(op1) / $signed(op2));
          alu_extra  = 16'($signed(op1) % $signed(op2));
        end
      end
      scd_pkg::SCD_ALU_AND: alu_result = op1 & op2;
      scd_pkg::SCD_ALU_OR:  alu_result = op1 | op2;
      scd_pkg::SCD_ALU_XOR: alu_result = op1 ^ op2;
      scd_pkg::SCD_ALU_NOT: alu_result = ~op1;
      scd_pkg::SCD_ALU_NEG: alu_result = 16'(16'h0000 - op1);
      default:              alu_result = scd_pkg::ZERO_VAL;
    endcase
  end

  // ==========================================================================
  // Shift unit
  // shift unit instance
  scd_shifter u_shifter (
    .din    (op1),
    .amount (op2[3:0]),
    .op     (shift_op),
    .dout   (shift_result)
  );

  // ==========================================================================
  // Branch unit
  // two comparators only
  assign cmp_eq = (op1 == op2);
  assign cmp_gt = ($signed(op1) > $signed(op2));

  always_comb begin
    case (branch_cond)
      scd_pkg::SCD_CND_ALWAYS: branch_taken = 1'b1;
      scd_pkg::SCD_CND_EQ:     branch_taken = cmp_eq;
      scd_pkg::SCD_CND_NE:     branch_taken = !cmp_eq;
      scd_pkg::SCD_CND_GT:     branch_taken = cmp_gt;
      scd_pkg::SCD_CND_GE:     branch_taken = cmp_gt || cmp_eq;
      scd_pkg::SCD_CND_LT:     branch_taken = !cmp_gt && !cmp_eq;
      scd_pkg::SCD_CND_LE:     branch_taken = !cmp_gt;
      default:                 branch_taken = 1'b0;
    endcase
  end

  // ==========================================================================
  // Load/store, I/O and video routing
  // operands onto data memory
  // loads and stores only reach data memory
  always_comb begin
    dmem_addr  = op2;
    dmem_wdata = op1;
    dmem_we    = dmem_write_en;
  end

  always_comb begin
    io_addr  = op2[IO_ADDR_W-1:0];
    io_wdata = op1[IO_DATA_W-1:0];
    io_rd    = io_read_en;
    io_wr    = io_write_en;
  end

  always_comb begin
    vid_addr = op2;
    vid_data = op1;
    vid_we   = video_write_en;
  end

  // ==========================================================================
  // Writeback
  // Control waits the extra cycle for load data
  // single writeback mux
  always_comb begin
    case (wb_sel)
      scd_pkg::SCD_WB_ALU:   wb_data = alu_result;
      scd_pkg::SCD_WB_SHIFT: wb_data = shift_result;
      scd_pkg::SCD_WB_DMEM:  wb_data = dmem_rdata;
      scd_pkg::SCD_WB_IO:    wb_data = 16'(io_rdata);
      scd_pkg::SCD_WB_OPER:  wb_data = op1;
      default:               wb_data = alu_result;
    endcase
  end

  assign rf.wr_en   = rf_write_en;
  assign rf.wr_idx  = ir[scd_pkg::REGA_LSB +: scd_pkg::FIELD_W];
  assign rf.wr_data = wb_data;

  assign rf.tmp_wr_en = rf_write_en && (wb_sel == scd_pkg::SCD_WB_ALU) && alu_has_extra;
  assign rf.tmp_data  = alu_extra;

  scd_regfile u_regfile (
    .clk (clk),
    .rst (rst),
    .bus (rf.rf)
  );

endmodule

`default_nettype wire

/* scd_dp_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Port checker for the datapath
module scd_dp_assertions #(
  parameter int unsigned IO_ADDR_W = 8,
  parameter int unsigned IO_DATA_W = 8
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 pc_load_en,
  input wire logic                 ir_load_en,
  input wire logic                 branch_en,
  input wire logic                 return_en,
  input wire scd_pkg::scd_cond_e   branch_cond,
  input wire logic                 op2_load_en,
  input wire logic                 op2_imm_sel,
  input wire logic                 ldst_instr,
  input wire logic                 dmem_write_en,
  input wire logic                 io_read_en,
  input wire logic                 io_write_en,
  input wire logic                 video_write_en,
  input wire logic [3:0]           opcode,
  input wire logic [3:0]           func_field,
  input wire logic                 branch_taken,
  input wire logic [15:0]          imem_addr,
  input wire logic [15:0]          imem_rdata,
  input wire logic [15:0]          dmem_addr,
  input wire logic [15:0]          dmem_wdata,
  input wire logic                 dmem_we,
  input wire logic [IO_ADDR_W-1:0] io_addr,
  input wire logic [IO_DATA_W-1:0] io_wdata,
  input wire logic                 io_rd,
  input wire logic                 io_wr,
  input wire logic [15:0]          vid_addr,
  input wire logic [15:0]          vid_data,
  input wire logic                 vid_we
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Strobes are plain copies of the enables
  strobe_copy_a: assert property (
    dmem_we == dmem_write_en && io_rd == io_read_en && io_wr == io_write_en
    && vid_we == video_write_en) else $error("bus strobe differs from enable");
  // All side buses show the same operands
  bus_share_a: assert property (
    vid_addr == dmem_addr && vid_data == dmem_wdata
    && io_addr == dmem_addr[IO_ADDR_W-1:0] && io_wdata == dmem_wdata[IO_DATA_W-1:0])
    else $error("operand buses disagree");
  pc_step_a: assert property (
    pc_load_en && !branch_en && !return_en |=> imem_addr == $past(imem_addr) + 16'h0001)
    else $error("pc did not step");
  pc_hold_a: assert property (
    !pc_load_en && !return_en |=> $stable(imem_addr))
    else $error("pc moved without load");
  ir_fields_a: assert property (
    ir_load_en |=> opcode == $past(imem_rdata[3:0]) && func_field == $past(imem_rdata[7:4]))
    else $error("instruction fields misplaced");
  imm_load_a: assert property (
    op2_load_en && op2_imm_sel && ldst_instr |=> dmem_addr == $past(imem_rdata))
    else $error("immediate not in operand two");
  cond_eq_a: assert property (
    branch_cond == scd_pkg::SCD_CND_EQ |-> branch_taken == (dmem_wdata == dmem_addr))
    else $error("equal condition wrong");
  cond_gt_a: assert property (
    branch_cond == scd_pkg::SCD_CND_GT
    |-> branch_taken == ($signed(dmem_wdata) > $signed(dmem_addr)))
    else $error("greater condition wrong");
  cond_fixed_a: assert property (
    branch_cond inside {scd_pkg::SCD_CND_ALWAYS, scd_pkg::SCD_CND_NEVER}
    |-> branch_taken == (branch_cond == scd_pkg::SCD_CND_ALWAYS))
    else $error("fixed condition wrong");
endmodule

`default_nettype wire

/* scd_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Separate instruction and data word memories
module scd_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] imem_addr,
  output logic      [15:0] imem_rdata,
  input  wire logic [15:0] dmem_addr,
  input  wire logic [15:0] dmem_wdata,
  input  wire logic        dmem_we,
  output logic      [15:0] dmem_rdata
);
  logic [15:0] imem [65536];
  logic [15:0] dmem [65536];

  assign imem_rdata = imem[imem_addr];

  // registered read, data lags address by one cycle
  always @(posedge clk) begin
    if (dmem_we) begin
      dmem[dmem_addr] <= dmem_wdata;
    end
    dmem_rdata <= dmem[dmem_addr];
  end
endmodule

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Datapath bench
module tb;
  localparam logic [15:0] PCL = 16'h8000, IRL = 16'h4000, BTL = 16'h2000,
    BRE = 16'h1000, CAL = 16'h0800, RTN = 16'h0400,
    O1 = 16'h0200, O2 = 16'h0100, I2 = 16'h0040,
    LS = 16'h0020, WR = 16'h0010, DW = 16'h0008,
    IOR = 16'h0004, IOW = 16'h0002, VW = 16'h0001;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [15:0]          ctl;
  logic                 pc_load_en, ir_load_en, bt_load_en, branch_en, call_en, return_en;
  logic                 op1_load_en, op2_load_en, op1_imm_sel, op2_imm_sel, ldst_instr;
  logic                 rf_write_en, dmem_write_en, io_read_en, io_write_en, video_write_en;
  scd_pkg::scd_cond_e   branch_cond;
  scd_pkg::scd_alu_op_e alu_op;
  scd_pkg::scd_shf_op_e shift_op;
  scd_pkg::scd_wb_sel_e wb_sel;
  logic [3:0]           opcode, func_field;
  logic                 branch_taken, stack_empty, stack_full, dmem_we, io_rd, io_wr, vid_we;
  logic [15:0]          imem_addr, imem_rdata, dmem_addr, dmem_wdata, dmem_rdata;
  logic [15:0]          vid_addr, vid_data, pc_exp, last_ret;
  logic [7:0]           io_addr, io_wdata, io_rdata;
  int                   error_cnt = 0;
  int                   checks = 0;

  // One word drives all enables, so each changes once a cycle
  assign {pc_load_en, ir_load_en, bt_load_en, branch_en, call_en, return_en, op1_load_en,
          op2_load_en, op1_imm_sel, op2_imm_sel, ldst_instr, rf_write_en, dmem_write_en,
          io_read_en, io_write_en, video_write_en} = ctl;
  // Peripheral answers while read, shows the inverse otherwise
  assign io_rdata = io_rd ? 8'hA5 : 8'h5A;

  always #20 clk = ~clk;

  scd_datapath #(.RET_DEPTH(2)) scd_datapath_inst (.*);
  scd_mem_model scd_mem_model_inst (.*);

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] seen, want);
    checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [15:0] v);
    ctl = v;
    #5;
  endtask
  task automatic cyc(input logic [15:0] v);
    put(v);
    tick();
  endtask
  task automatic fetch(input logic [15:0] w);
    scd_mem_model_inst.imem[pc_exp] = w;
    cyc(PCL | IRL);
    pc_exp++;
    chk("pc", imem_addr, pc_exp);
  endtask
  // Absolute load: data used one cycle later
  task automatic ld(input logic [3:0] r, input logic [15:0] a, v);
    scd_mem_model_inst.dmem[a] = v;
    fetch({4'h0, r, 8'h00});
    scd_mem_model_inst.imem[pc_exp] = a;
    cyc(PCL | O2 | I2 | LS);
    pc_exp++;
    chk("load addr", dmem_addr, a);
    cyc(16'h0000);
    wb_sel = scd_pkg::SCD_WB_DMEM;
    cyc(WR);
  endtask
  task automatic rd(input logic [3:0] a, b, input logic [15:0] ea, eb);
    fetch({b, a, 8'h00});
    cyc(O1 | O2);
    chk("op1", dmem_wdata, ea);
    chk("op2", dmem_addr, eb);
  endtask
  task automatic ex(input scd_pkg::scd_alu_op_e op, input scd_pkg::scd_wb_sel_e s);
    fetch({4'h2, 4'h1, 8'h00});
    cyc(O1 | O2);
    alu_op = op;
    wb_sel = s;
    cyc(WR);
  endtask
  task automatic br(input logic [15:0] tgt, c, input logic taken);
    fetch({4'h2, 4'h1, 8'h00});
    scd_mem_model_inst.imem[pc_exp] = tgt;
    cyc(PCL | BTL);
    pc_exp++;
    cyc(O1 | O2);
    last_ret = pc_exp;
    cyc(c);
    if (taken) pc_exp = tgt;
    chk("branch pc", imem_addr, pc_exp);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_const();
    ld(4'hE, 16'h0020, 16'h1234);
    ld(4'hF, 16'h0021, 16'h0000);
    ld(4'hC, 16'h0022, 16'hBEEF);
    rd(4'hE, 4'hF, 16'h0000, 16'hFFFF);
    rd(4'hC, 4'hC, 16'hBEEF, 16'hBEEF);
  endtask
  task automatic t_alu();
    ld(4'h1, 16'h0023, 16'h0100);
    ld(4'h2, 16'h0024, 16'h0300);
    ex(scd_pkg::SCD_ALU_MUL, scd_pkg::SCD_WB_ALU);
    rd(4'h1, 4'hD, 16'h0000, 16'h0003);
    ld(4'h1, 16'h0023, 16'h0007);
    ld(4'h2, 16'h0024, 16'h0002);
    ex(scd_pkg::SCD_ALU_DIV, scd_pkg::SCD_WB_ALU);
    ld(4'hD, 16'h0025, 16'h7777);
    ex(scd_pkg::SCD_ALU_ADD, scd_pkg::SCD_WB_ALU);
    rd(4'h1, 4'hD, 16'h0005, 16'h0001);
  endtask
  task automatic t_shift();
    logic [15:0] ev [6] = '{16'h000C, 16'h3000, 16'h0008, 16'h1000, 16'h0008, 16'hF000};
    ld(4'h2, 16'h0026, 16'h0003);
    for (int i = 0; i < 6; i++) begin
      ld(4'h1, 16'h0027, 16'h8001);
      shift_op = scd_pkg::scd_shf_op_e'(i);
      ex(scd_pkg::SCD_ALU_ADD, scd_pkg::SCD_WB_SHIFT);
      rd(4'h1, 4'h2, ev[i], 16'h0003);
    end
  endtask
  task automatic t_branch();
    logic [7:0]  tk = 8'b00011101;
    logic [15:0] r1;
    ld(4'h1, 16'h0028, 16'h0005);
    ld(4'h2, 16'h0029, 16'hFFFD);
    rd(4'h1, 4'h2, 16'h0005, 16'hFFFD);
    for (int i = 0; i < 8; i++) begin
      branch_cond = scd_pkg::scd_cond_e'(i);
      #1;
      chk("taken", branch_taken, tk[i]);
    end
    branch_cond = scd_pkg::SCD_CND_LT;
    br(16'h0400, BRE, 1'b0);
    branch_cond = scd_pkg::SCD_CND_GT;
    br(16'h0300, PCL | BRE, 1'b1);
    branch_cond = scd_pkg::SCD_CND_ALWAYS;
    br(16'h0500, PCL | BRE | CAL, 1'b1);
    r1 = last_ret;
    br(16'h0600, PCL | BRE | CAL, 1'b1);
    chk("full", stack_full, 16'h0001);
    cyc(PCL | RTN);
    chk("return", imem_addr, last_ret);
    cyc(PCL | RTN);
    chk("return", imem_addr, r1);
    chk("empty", stack_empty, 16'h0001);
    pc_exp = r1;
  endtask
  task automatic t_bus();
    ld(4'h3, 16'h002A, 16'hC35A);
    fetch({4'h0, 4'h3, 8'h00});
    scd_mem_model_inst.imem[pc_exp] = 16'h0040;
    scd_mem_model_inst.imem[16'h0040] = 16'h1111;
    cyc(PCL | O1 | O2 | I2 | LS);
    pc_exp++;
    put(DW | IOW | VW);
    chk("io addr", {8'h00, io_addr}, 16'h0040);
    chk("io data", {8'h00, io_wdata}, 16'h005A);
    chk("vid data", vid_data, 16'hC35A);
    chk("io wr", io_wr, 16'h0001);
    tick();
    chk("store", scd_mem_model_inst.dmem[16'h0040], 16'hC35A);
    chk("code", scd_mem_model_inst.imem[16'h0040], 16'h1111);
    wb_sel = scd_pkg::SCD_WB_IO;
    put(IOR | WR);
    chk("io rd", io_rd, 16'h0001);
    tick();
    rd(4'h3, 4'h3, 16'h00A5, 16'h00A5);
    fetch({4'h3, 4'h3, 8'h96});
    chk("fields", {8'h00, func_field, opcode}, 16'h0096);
    scd_mem_model_inst.imem[pc_exp] = 16'h0077;
    cyc(O2 | I2);
    chk("no imm", dmem_addr, 16'h00A5);
  endtask

  // ==========================================================================
  // Verdict, watchdog and main sequence
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Run is under 2000 cycles; five times that is a hang
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    ctl = 16'h0000;
    alu_op = scd_pkg::SCD_ALU_ADD;
    shift_op = scd_pkg::SCD_SHF_ROL;
    branch_cond = scd_pkg::SCD_CND_ALWAYS;
    wb_sel = scd_pkg::SCD_WB_ALU;
    pc_exp = 16'h0000;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("pc reset", imem_addr, 16'h0000);
    chk("stack reset", stack_empty, 16'h0001);
    t_const();
    t_alu();
    t_shift();
    t_branch();
    t_bus();
    print_verdict();
  end
endmodule

bind scd_datapath scd_dp_assertions #(
  .IO_ADDR_W(IO_ADDR_W),
  .IO_DATA_W(IO_DATA_W)
) scd_dp_assertions_inst (.*);

`default_nettype wire
